//--- rtl/ind_mon_pkg.sv
package ind_mon_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_IND      = 10;  // monitored indicators
  localparam int N_STATE    = 4;   // decoded states per indicator
  localparam int LOG_DEPTH  = 16;  // event log entries
  localparam int ADDR_W     = 8;   // apb address width
  localparam int DATA_W     = 32;  // apb data width
  localparam int TS_W       = 32;  // time stamp width
  localparam int INFO_W     = 8;   // event info width
  localparam int ENTRY_W    = TS_W + INFO_W;
  localparam int CFG_W      = 10;  // per-indicator config width

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;  // CLOCK rate
  localparam int TICK_US     = 1000;        // stamp resolution, 1 ms
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ST_INTERMEDIATE = 2'h0;
  localparam logic [1:0] ST_OPEN         = 2'h1;
  localparam logic [1:0] ST_CLOSED       = 2'h2;
  localparam logic [1:0] ST_BAD          = 2'h3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h00;  // status codes, ro
  localparam logic [7:0] OFS_SW_SRC   = 8'h04;  // software sources, rw
  localparam logic [7:0] OFS_EVT_CNT  = 8'h08;  // log fill level, ro
  localparam logic [7:0] OFS_EVT_INFO = 8'h0c;  // head entry info, ro
  localparam logic [7:0] OFS_EVT_TIME = 8'h10;  // head stamp, ro, pops
  localparam logic [7:0] OFS_IRQ_ST   = 8'h14;  // sticky, read clears
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;  // interrupt mask, rw
  localparam logic [7:0] OFS_TIME     = 8'h1c;  // ms counter, ro
  localparam logic [7:0] OFS_CFG      = 8'h40;  // config per indicator

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int SW_CLOSE_LSB = 16;  // close bits in software source
  localparam int CFG_USE_SW   = 0;   // take software source
  localparam int CFG_SINGLE   = 1;   // single input, close = not open
  localparam int CFG_ON_LSB   = 2;   // on-event enables, 4 bits
  localparam int CFG_OFF_LSB  = 6;   // off-event enables, 4 bits
  localparam int INFO_ST_LSB  = 4;   // state field in info
  localparam int INFO_ON_BIT  = 6;   // on/off flag in info
  localparam int IRQ_EVT      = 0;   // event logged
  localparam int IRQ_OVF      = 1;   // event dropped, log full
  localparam int IRQ_W        = 2;

  // one-hot of a status code: intermediate, open, closed, bad
  function automatic logic [N_STATE-1:0] state_onehot(input logic [1:0] code);
    state_onehot = 4'h1 << code;
  endfunction : state_onehot
endpackage : ind_mon_pkg

//--- rtl/log_mem_if.sv
`timescale 1ns/1ns
interface log_mem_if #(
  parameter int AW = 4,
  parameter int W  = 40
);
  logic          we;     // write strobe
  logic [AW-1:0] waddr;  // write address
  logic [W-1:0]  wdata;  // write data
  logic [AW-1:0] raddr;  // read address
  logic [W-1:0]  rdata;  // registered read data

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : log_mem_if

//--- rtl/event_log_mem.sv
`timescale 1ns/1ns
module event_log_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 40
) (
  // clock
  input wire logic  clock,
  // port
  log_mem_if.mem    port
);
  logic [W-1:0] mem_r [DEPTH];  // entry storage

  // ----------------------------------------------------------------
  // write, and registered read with write bypass
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (port.we)
    begin
      mem_r[port.waddr] <= port.wdata;
    end
    // bypass so a fresh head entry is seen at once
    port.rdata <= (port.we && port.waddr == port.raddr) ? port.wdata : mem_r[port.raddr];
  end
endmodule : event_log_mem

//--- rtl/status_decoder.sv
`timescale 1ns/1ns
module status_decoder (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // sources
  input  wire logic       hw_open,
  input  wire logic       hw_close,
  input  wire logic       sw_open,
  input  wire logic       sw_close,
  // setup
  input  wire logic       use_sw,
  input  wire logic       single,
  // decoded state
  output logic      [1:0] code,
  output logic      [3:0] rise,
  output logic      [3:0] fall
);
  logic       open_sel;   // chosen open source
  logic       close_raw;  // chosen close source
  logic       close_sel;  // close after single-input option
  logic [1:0] code_nxt;   // next status code
  logic [1:0] code_r;     // current status code
  logic [3:0] oh_now;     // one-hot of current
  logic [3:0] oh_nxt;     // one-hot of next

  // ----------------------------------------------------------------
  // source select and decode
  // ----------------------------------------------------------------
  assign open_sel  = use_sw ? sw_open : hw_open;   // [R9] [R4]
  assign close_raw = use_sw ? sw_close : hw_close; // [R9] [R5] [R6]
  assign close_sel = single ? ~open_sel : close_raw; // [R7]
  // code is {close, open}: 0 neither, 1 open, 2 closed, 3 both
  assign code_nxt  = {close_sel, open_sel}; // [R1] [R2] [R3] [R15]
  assign oh_now    = ind_mon_pkg::state_onehot(code_r);
  assign oh_nxt    = ind_mon_pkg::state_onehot(code_nxt);
  assign rise      = oh_nxt & ~oh_now; // [R16]
  assign fall      = oh_now & ~oh_nxt; // [R16]
  assign code      = code_r;

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      code_r <= ind_mon_pkg::ST_INTERMEDIATE;
    else
      code_r <= code_nxt;
  end
endmodule : status_decoder

//--- rtl/indicator_monitor_event_block.sv
`timescale 1ns/1ns
//
// Contract
// R1 - status codes intermediate, open, closed, bad
// R2 - neither input active gives intermediate
// R3 - both inputs active gives bad
// R4 - open input high means open
// R5 - close input high means closed
// R6 - two separate inputs per indicator
// R7 - single input with inverted copy
// R8 - indication only, no control outputs
// R9 - pin or software signal sources
// R10 - on and off events per state
// R11 - events stamped at 1 ms resolution
// R12 - per event choose on, off, both
// R13 - ten independent indicator instances
// R14 - settings change only during setup
// R15 - open or closed needs exclusive inputs
// R16 - events on every state change
module indicator_monitor_event_block #(
  parameter int N_IND       = ind_mon_pkg::N_IND,
  parameter int LOG_DEPTH   = ind_mon_pkg::LOG_DEPTH,
  parameter int TICK_CYCLES = ind_mon_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic             CLOCK,
  input  wire logic             RST_B,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // digital inputs
  input  wire logic [N_IND-1:0] DI_OPEN,
  input  wire logic [N_IND-1:0] DI_CLOSE,
  // interrupt
  output logic                  IRQ
);
  localparam int AW  = $clog2(LOG_DEPTH);
  localparam int NP  = N_IND * ind_mon_pkg::N_STATE;  // flags per polarity
  localparam int PW  = $clog2(2 * NP);
  localparam int EW  = ind_mon_pkg::ENTRY_W;
  localparam int TW  = ind_mon_pkg::TS_W;
  localparam logic [AW:0]  DEPTH_C = (AW + 1)'(LOG_DEPTH);
  localparam logic [31:0]  TICK_LAST = 32'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [N_IND-1:0] open_m_r;   // first stage
  logic [N_IND-1:0] open_s_r;   // second stage
  logic [N_IND-1:0] close_m_r;  // first stage
  logic [N_IND-1:0] close_s_r;  // second stage

  // two flops before any logic reads a pin
  always_ff @(posedge CLOCK)
  begin
    open_m_r  <= DI_OPEN;
    open_s_r  <= open_m_r;
    close_m_r <= DI_CLOSE;
    close_s_r <= close_m_r;
  end

  // ----------------------------------------------------------------
  // setting registers
  // ----------------------------------------------------------------
  logic [31:0]                   sw_src_r;              // software sources
  logic [ind_mon_pkg::CFG_W-1:0] cfg_r [N_IND];         // per indicator
  logic [ind_mon_pkg::IRQ_W-1:0] irq_mask_r;            // mask
  logic [ind_mon_pkg::IRQ_W-1:0] irq_st_r;              // sticky status
  logic [ind_mon_pkg::IRQ_W-1:0] irq_set;               // events this cycle
  logic [ind_mon_pkg::IRQ_W-1:0] irq_clr;               // read clear
  logic [31:0]                   rd_snap_r;             // read value at the last setup

  // ----------------------------------------------------------------
  // decoders, one per indicator
  // ----------------------------------------------------------------
  logic [2*N_IND-1:0] codes;    // packed status codes
  logic [NP-1:0]      rise_v;   // states entered
  logic [NP-1:0]      fall_v;   // states left
  logic [NP-1:0]      on_en;    // on enables
  logic [NP-1:0]      off_en;   // off enables

  // ten instances, each with its own eight events, on and off for four states
  for (genvar i = 0; i < N_IND; i++)
  begin : g_ind // [R13]
    status_decoder u_dec (
      .clock    (CLOCK),
      .rst_b    (RST_B),
      .hw_open  (open_s_r[i]),
      .hw_close (close_s_r[i]),
      .sw_open  (sw_src_r[i]),
      .sw_close (sw_src_r[ind_mon_pkg::SW_CLOSE_LSB + i]),
      .use_sw   (cfg_r[i][ind_mon_pkg::CFG_USE_SW]),
      .single   (cfg_r[i][ind_mon_pkg::CFG_SINGLE]),
      .code     (codes[2*i +: 2]),
      .rise     (rise_v[4*i +: 4]),
      .fall     (fall_v[4*i +: 4])
    );
    assign on_en[4*i +: 4]  = cfg_r[i][ind_mon_pkg::CFG_ON_LSB +: 4];
    assign off_en[4*i +: 4] = cfg_r[i][ind_mon_pkg::CFG_OFF_LSB +: 4];
  end

  // ----------------------------------------------------------------
  // millisecond time stamp
  // ----------------------------------------------------------------
  logic [31:0]   tick_cnt_r;  // cycles within a ms
  logic [TW-1:0] ms_r;        // ms count

  // free-running ms counter for stamping
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      tick_cnt_r <= 32'h0;
      ms_r       <= '0;
    end
    else if (tick_cnt_r == TICK_LAST)
    begin
      tick_cnt_r <= 32'h0;
      ms_r       <= ms_r + 1'b1; // [R11]
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // pending events and selection
  // ----------------------------------------------------------------
  logic [2*NP-1:0] pend_r;     // on flags low, off flags high
  logic [2*NP-1:0] pend_set;   // new events, filtered
  logic [2*NP-1:0] pend_clr;   // event taken this cycle
  logic [PW-1:0]   pick;       // chosen flag
  logic            pick_ok;    // a flag is pending
  logic            pick_on;    // chosen one is an on event
  logic [PW-1:0]   pick_rel;   // index within its polarity
  logic [EW-1:0]   entry;      // log word

  // lowest pending flag
  function automatic logic [PW:0] first_set(input logic [2*NP-1:0] v);
    first_set = '0;
    for (int k = 2*NP-1; k >= 0; k--)
    begin
      if (v[k])
        first_set = {1'b1, PW'(k)};
    end
  endfunction : first_set

  assign pend_set = {fall_v & off_en, rise_v & on_en};     // [R10] [R12]
  assign {pick_ok, pick} = first_set(pend_r);
  assign pick_on  = (pick < PW'(NP));
  assign pick_rel = pick_on ? pick : PW'(pick - PW'(NP));
  assign pend_clr = pick_ok ? ((2*NP)'(1) << pick) : '0;
  // info: indicator number, state, on flag; then the ms stamp
  assign entry    = {1'b0, pick_on, pick_rel[1:0], pick_rel[5:2], ms_r}; // [R11]

  // new events win over the flag being taken
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
      pend_r <= '0;
    else
      pend_r <= (pend_r & ~pend_clr) | pend_set; // [R16]
  end

  // ----------------------------------------------------------------
  // event log ring
  // ----------------------------------------------------------------
  logic [AW-1:0] wr_ptr_r;   // next free slot
  logic [AW-1:0] rd_ptr_r;   // head slot
  logic [AW:0]   cnt_r;      // entries held
  logic          log_full;   // no room
  logic          push;       // write entry
  logic          pop;        // head read out
  logic          drop;       // event lost

  log_mem_if #(.AW(AW), .W(EW)) mem_bus ();

  event_log_mem #(.DEPTH(LOG_DEPTH), .AW(AW), .W(EW)) u_mem (
    .clock (CLOCK),
    .port  (mem_bus.mem)
  );

  assign log_full      = (cnt_r == DEPTH_C);
  assign push          = pick_ok & ~log_full; // [R10]
  assign drop          = pick_ok & log_full;
  assign mem_bus.we    = push;
  assign mem_bus.waddr = wr_ptr_r;
  assign mem_bus.wdata = entry;
  // read ahead so the head is ready for the next transfer
  assign mem_bus.raddr = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;

  // ring pointers and fill level
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      cnt_r    <= AW'(0) + cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup;     // first cycle of a transfer
  logic        access;    // completing edge
  logic        wr_acc;    // write takes effect
  logic        rd_acc;    // read side effects
  logic [7:0]  cfg_ofs;   // offset into config block
  logic [7:0]  cfg_idx;   // config index
  logic        hit_cfg;   // config register addressed
  logic        hit;       // any register addressed
  logic [31:0] rd_mux;    // read value
  logic [31:0] cfg_rd;    // selected config
  logic        pready_r;  // answer
  logic [31:0] prdata_r;  // read data
  logic        pslverr_r; // unmapped
  logic        irq_r;     // interrupt level
  logic [31:0] head_info; // head info word
  logic [31:0] head_time; // head stamp word

  assign setup   = PSEL & ~PENABLE;
  assign access  = PSEL & PENABLE & pready_r;
  assign wr_acc  = access & PWRITE & hit;
  assign rd_acc  = access & ~PWRITE;
  assign cfg_ofs = PADDR - ind_mon_pkg::OFS_CFG;
  assign cfg_idx = {2'h0, cfg_ofs[7:2]};
  assign hit_cfg = (PADDR >= ind_mon_pkg::OFS_CFG) && (cfg_idx < 8'(N_IND))
                   && (PADDR[1:0] == 2'h0);
  assign cfg_rd  = hit_cfg ? 32'(cfg_r[cfg_idx[3:0]]) : 32'h0;
  assign pop     = rd_acc && PADDR == ind_mon_pkg::OFS_EVT_TIME && cnt_r != '0;
  assign head_info = (cnt_r != '0) ? 32'(mem_bus.rdata[EW-1:TW]) : 32'h0;
  assign head_time = (cnt_r != '0) ? mem_bus.rdata[TW-1:0] : 32'h0;
  assign hit     = hit_cfg
                 || PADDR == ind_mon_pkg::OFS_STATUS   || PADDR == ind_mon_pkg::OFS_SW_SRC
                 || PADDR == ind_mon_pkg::OFS_EVT_CNT  || PADDR == ind_mon_pkg::OFS_EVT_INFO
                 || PADDR == ind_mon_pkg::OFS_EVT_TIME || PADDR == ind_mon_pkg::OFS_IRQ_ST
                 || PADDR == ind_mon_pkg::OFS_IRQ_MASK || PADDR == ind_mon_pkg::OFS_TIME;
  assign rd_mux  = (PADDR == ind_mon_pkg::OFS_STATUS)   ? 32'(codes) : // [R1]
                   (PADDR == ind_mon_pkg::OFS_SW_SRC)   ? sw_src_r :
                   (PADDR == ind_mon_pkg::OFS_EVT_CNT)  ? 32'(cnt_r) :
                   (PADDR == ind_mon_pkg::OFS_EVT_INFO) ? head_info :
                   (PADDR == ind_mon_pkg::OFS_EVT_TIME) ? head_time :
                   (PADDR == ind_mon_pkg::OFS_IRQ_ST)   ? 32'(irq_st_r) :
                   (PADDR == ind_mon_pkg::OFS_IRQ_MASK) ? 32'(irq_mask_r) :
                   (PADDR == ind_mon_pkg::OFS_TIME)     ? ms_r : cfg_rd;

  // only bits seen by the read are cleared
  assign irq_clr = (rd_acc && PADDR == ind_mon_pkg::OFS_IRQ_ST)
                   ? rd_snap_r[ind_mon_pkg::IRQ_W-1:0] : '0;
  assign irq_set = {drop, push};

  // ----------------------------------------------------------------
  // apb answer: data latched in setup, ready in access
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
      rd_snap_r <= 32'h0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;  // one cycle, with ready
      if (setup)
      begin
        prdata_r  <= PWRITE ? 32'h0 : rd_mux;
        rd_snap_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes; settings are static in use
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      sw_src_r   <= 32'h0;
      irq_mask_r <= '0;
      for (int k = 0; k < N_IND; k++)
        cfg_r[k] <= '0;
    end
    else if (wr_acc)
    begin
      // the setup phase is software's duty [R14]
      if (PADDR == ind_mon_pkg::OFS_SW_SRC)
        sw_src_r <= PWDATA; // [R9]
      else if (PADDR == ind_mon_pkg::OFS_IRQ_MASK)
        irq_mask_r <= PWDATA[ind_mon_pkg::IRQ_W-1:0];
      else if (hit_cfg)
        cfg_r[cfg_idx[3:0]] <= PWDATA[ind_mon_pkg::CFG_W-1:0]; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, set wins over read clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      irq_st_r <= '0;
      irq_r    <= 1'b0;
    end
    else
    begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
      irq_r    <= |(irq_st_r & irq_mask_r);
    end
  end

  // outputs straight from flops; no control outputs exist [R8]
  assign PREADY  = pready_r;
  assign PRDATA  = prdata_r;
  assign PSLVERR = pslverr_r;
  assign IRQ     = irq_r;
endmodule : indicator_monitor_event_block

//--- verification/ind_mon_chk.sv
`timescale 1ns/1ns
module ind_mon_chk #(
  parameter int N_IND = 10,
  parameter int TICK  = 50000  // cycles per ms
) (
  // clock and reset
  input wire logic             CLOCK,
  input wire logic             RST_B,
  // apb
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [7:0]       PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic [31:0]      PRDATA,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  // pins and interrupt
  input wire logic [N_IND-1:0] DI_OPEN,
  input wire logic [N_IND-1:0] DI_CLOSE,
  input wire logic             IRQ
);
  // ------
  // shadows
  // ------
  logic [31:0] sw_r;   // software sources
  logic [1:0]  msk_r;  // interrupt mask
  logic [1:0]  cfg_r;  // source bits of indicator 0
  logic [1:0]  di_r;   // last pins of indicator 0
  logic [3:0]  stb_r;  // cycles those pins held
  int          tk_r;   // cycles within a ms
  logic [31:0] ms_r;   // ms count shadow
  wire  [1:0]  di_now  = {DI_CLOSE[0], DI_OPEN[0]};
  wire         wr_done = PSEL && PENABLE && PREADY && PWRITE;
  wire         rd_done = PSEL && PENABLE && PREADY && !PWRITE;

  // follow completed writes and pin stability
  always_ff @(posedge CLOCK)
    if (!RST_B)
    begin
      sw_r  <= 32'h0;
      msk_r <= 2'h0;
      cfg_r <= 2'h0;
      di_r  <= 2'h0;
      stb_r <= 4'h0;
      tk_r  <= 0;
      ms_r  <= 32'h0;
    end
    else
    begin
      sw_r  <= (wr_done && PADDR == 8'h04) ? (PWDATA & 32'h03ff03ff) : sw_r;
      msk_r <= (wr_done && PADDR == 8'h18) ? PWDATA[1:0] : msk_r;
      cfg_r <= (wr_done && PADDR == 8'h40) ? PWDATA[1:0] : cfg_r;
      di_r  <= di_now;
      stb_r <= (di_now != di_r) ? 4'h0 : ((stb_r == 4'hf) ? stb_r : stb_r + 4'h1);
      tk_r  <= (tk_r == TICK - 1) ? 0 : tk_r + 1;
      ms_r  <= (tk_r == TICK - 1) ? ms_r + 32'h1 : ms_r;
    end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  AST_READY:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  AST_READY_ONE:
    assert property (PREADY |=> !PREADY) else $error("ready held too long");
  AST_READY_BUS:
    assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  AST_ERR_ANSWER:
    assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0)) else $error("bad refusal");
  AST_ERR_MAPPED:
    assert property (PREADY && PADDR < 8'h20 |-> !PSLVERR) else $error("mapped place refused");
  AST_STATUS:
    assert property (rd_done && PADDR == 8'h00 && cfg_r == 2'h0 && stb_r > 4'h5
      |-> PRDATA[1:0] == di_r) else $error("status code wrong");
  AST_SW_BACK:
    assert property (rd_done && PADDR == 8'h04 |-> (PRDATA & 32'h03ff03ff) == sw_r)
      else $error("software sources lost");
  AST_LOG_FILL:
    assert property (rd_done && PADDR == 8'h08 |-> PRDATA <= 32'h10) else $error("fill too big");
  AST_IRQ_MASK:
    assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0 |-> !IRQ) else $error("masked irq");
  AST_TIME:
    assert property (rd_done && PADDR == 8'h1c |-> PRDATA == $past(ms_r))
      else $error("ms counter off");
  cover property (rd_done && PADDR == 8'h00 && stb_r > 4'h5);
  cover property ($rose(IRQ));
  cover property (PSLVERR);
endmodule : ind_mon_chk

//--- verification/contact_model.sv
`timescale 1ns/1ns
module contact_model #(
  parameter int TRAVEL = 4  // cycles between end positions
) (
  // clock
  input  wire logic        clock,
  // commanded positions, {close, open} per indicator
  input  wire logic [19:0] tgt,
  // auxiliary contacts
  output logic      [9:0]  c_open,
  output logic      [9:0]  c_close
);
  logic [1:0] cur [10];  // position moving to
  int         cnt [10];  // travel cycles left

  // both contacts drop while travelling, then show the target
  always @(posedge clock)
    for (int i = 0; i < 10; i++)
      if (tgt[2*i +: 2] != cur[i])
      begin
        cur[i]                  <= tgt[2*i +: 2];
        cnt[i]                  <= TRAVEL;
        {c_close[i], c_open[i]} <= 2'h0;
      end
      else if (cnt[i] != 0)
        cnt[i] <= cnt[i] - 1;
      else
        {c_close[i], c_open[i]} <= cur[i];

  // contacts idle at power-up
  initial
  begin
    c_open  = 10'h0;
    c_close = 10'h0;
    cur     = '{default: 2'h0};
    cnt     = '{default: 0};
  end
endmodule : contact_model

//--- verification/indicator_monitor_event_block_tb.sv
`timescale 1ns/1ns
module indicator_monitor_event_block_tb;
  // ------
  // bench
  // ------
  typedef struct {logic [31:0] e; logic [31:0] m; logic er;} note_t;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, cfg_a;
  logic [31:0] pwdata, prdata, sw;
  logic [9:0]  di_open, di_close;
  logic [19:0] tgt;       // commanded contact positions
  note_t       exp_q[$];  // expected answers, oldest first
  note_t       nt;
  int          errors, comparisons, k, seed;
  logic [7:0]  rv [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40};

  indicator_monitor_event_block #(.TICK_CYCLES(50)) i_dut (.CLOCK(clock), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DI_OPEN(di_open),
    .DI_CLOSE(di_close), .IRQ(irq));
  contact_model i_contacts (.clock(clock), .tgt(tgt), .c_open(di_open), .c_close(di_close));

  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // one apb transfer; psel stays up for a back-to-back setup
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic er);
    int n;
    n = 0;
    exp_q.push_back('{e, m, er});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    penable <= 1'b0;
    if (n >= 20)
    begin
      errors++;
      $display("[ERR] %0t no ready", $time);
      close_out();
    end
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic idle(input int c);
    psel <= 1'b0;
    repeat (c) @(posedge clock);
  endtask : idle

  task automatic chk_irq(input logic v);
    comparisons++;
    if (irq !== v)
    begin
      errors++;
      $display("[ERR] %0t irq %b", $time, irq);
    end
  endtask : chk_irq

  // clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // answer monitor, oldest note first
  always @(posedge clock)
    if (pready === 1'b1)
    begin
      nt = exp_q.pop_front();
      comparisons++;
      if ((prdata & nt.m) !== (nt.e & nt.m) || pslverr !== nt.er)
      begin
        errors++;
        $display("[ERR] %0t got %h want %h", $time, prdata, nt.e);
      end
    end

  // main sequence
  initial
  begin
    {rst_b, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, tgt} = '0;
    {errors, comparisons} = '0;
    seed = 32'h3e032722;
    k = {$random(seed)} % 10;
    cfg_a = 8'h40 + 8'(k * 4);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (rv[i]) rd(rv[i], 32'h0, 32'hffffffff);
    xfer(1'b0, 8'h20, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    xfer(1'b1, 8'h3c, 32'h1, 32'h0, 32'h0, 1'b1);
    wr(8'h18, 32'h1);
    wr(cfg_a, 32'h48);
    idle(2);
    tgt[2*k +: 2] <= 2'h1;
    idle(20);
    chk_irq(1'b1);
    rd(8'h08, 32'h2, 32'hffffffff);
    rd(8'h0c, 32'h50 | k, 32'h7f);
    rd(8'h10, 32'h0, 32'h0);
    rd(8'h0c, k, 32'h7f);
    rd(8'h10, 32'h0, 32'h0);
    rd(8'h14, 32'h1, 32'h3);
    rd(8'h14, 32'h0, 32'h3);
    rd(8'h1c, 32'h0, 32'h0);
    idle(3);
    chk_irq(1'b0);
    tgt[2*k +: 2] <= 2'h2;
    idle(20);
    rd(8'h08, 32'h1, 32'hffffffff);
    rd(8'h0c, k, 32'h7f);
    idle(1);
    for (int c = 0; c < 4; c++)
    begin
      tgt[2*k +: 2] <= 2'(c);
      idle(16);
      rd(8'h00, {12'h0, tgt}, 32'h000fffff);
    end
    wr(cfg_a, 32'h3);
    for (int b = 0; b < 2; b++)
    begin
      sw = $random(seed) & 32'h03ff03ff;
      sw[k] = b[0];
      wr(8'h04, sw);
      rd(8'h04, sw, 32'h03ff03ff);
      idle(8);
      rd(8'h00, (b ? 32'h1 : 32'h2) << (2 * k), 32'h3 << (2 * k));
    end
    // all events on, toggle the software source until the log overflows
    wr(cfg_a, 32'h3fd);
    for (int t = 0; t < 8; t++)
    begin
      wr(8'h04, 32'(t % 2) << k);
      idle(4);
    end
    rd(8'h08, 32'h10, 32'hffffffff);
    rd(8'h14, 32'h2, 32'h2);
    idle(4);
    close_out();
  end
endmodule : indicator_monitor_event_block_tb

bind indicator_monitor_event_block ind_mon_chk #(.N_IND(N_IND), .TICK(TICK_CYCLES)) i_chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DI_OPEN(DI_OPEN), .DI_CLOSE(DI_CLOSE), .IRQ(IRQ));
